//--- verilog/hpp_top.sv
// Functional notes
// - One generator drives one to three axes
// - Pulses come only from first input module
// - Generator counts pulses only while enabled; smoothed stop runs on after
// - Travel equals unit times pulses times gain
// - Unit: 0.1um, 1e-5 inch/degree, one pulse
// - Speed equals pulses per ms times gain
// - Select word: one bit per axis 1-32
// - Per-axis gain register, legal 1 to 10000
// - Smaller parts serve axes 1-16 or 1-8
// - Enable rise checks gain; bad means 1
// - Per-generator smoothing register, 0 to 59
// - Time constant is (smoothing+1) times 56.8 ms
// - Four or more selected: lowest three run
// - No valid selected axis: no operation
// - Hold start-accepted, refuse other starts
// - Enable on moving axis: error 214, ignore
`include "hpp_params.svh"
`default_nettype none
module hpp_top #(
   parameter int TICK_CYC = `HPP_TICK_NS / `HPP_CLK_NS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] gen_pulse,
   input wire logic [2:0] gen_dir,
   input wire logic [31:0] axis_busy,
   output hpp_pkg::hpp_cmd_s [2:0] cmd,
   output logic [31:0] start_accepted,
   output logic irq
);
   localparam hpp_pkg::hpp_state_s RST_S = '{gain: {32{`HPP_GAIN_RST}}, default: '0};
   hpp_pkg::hpp_state_s s_q;
   hpp_pkg::hpp_state_s s_d;
   logic [2:0][31:0] slot_mask;

   function automatic hpp_pkg::hpp_slot_s first3(input logic [31:0] m);
      hpp_pkg::hpp_slot_s r;
      logic [1:0] n;
      r = '0;
      n = 2'd0;
      for (int i = 0; i < 32; i++) begin
         if (m[i] && n != 2'd3) begin
            r.v[n] = 1'b1;
            r.ax[n] = 5'(i);
            n = n + 2'd1;
         end
      end
      return r;
   endfunction : first3

   ////////////////////////////////////////////////////////////////////////
   // Slot masks of the axes each generator holds
   always_comb begin
      for (int g = 0; g < 3; g++) begin
         slot_mask[g] = '0;
         for (int k = 0; k < 3; k++) begin
            if (s_q.g[g].sl.v[k]) begin
               slot_mask[g][s_q.g[g].sl.ax[k]] = 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic tick;
      logic wr;
      logic [31:0] rd;
      logic hit;
      logic signed [15:0] inc;
      logic signed [15:0] smp;
      logic signed [31:0] tgt;
      logic signed [39:0] num;
      logic signed [39:0] den;
      logic signed [39:0] step;
      logic [15:0] smo;
      logic [15:0] gn;
      logic conflict;
      logic [31:0] bad;
      logic [31:0] busy_m;
      hpp_pkg::hpp_slot_s sl;
      tick = 1'b0;
      wr = 1'b0;
      rd = '0;
      hit = 1'b1;
      inc = '0;
      smp = '0;
      tgt = '0;
      num = '0;
      den = '0;
      step = '0;
      smo = '0;
      gn = '0;
      conflict = 1'b0;
      bad = '0;
      busy_m = '0;
      sl = '0;
      s_d = s_q;

      tick = (s_q.tick == 16'(TICK_CYC - 1));
      s_d.tick = tick ? 16'h0000 : s_q.tick + 16'h0001;

      // APB read decode, answered in the access phase
      if (paddr[11:8] == `HPP_GAIN_PAGE && !paddr[7]) begin
         rd = {16'h0000, s_q.gain[paddr[6:2]]};
      end else begin
         unique case (paddr)
            `HPP_SEL1_OFF: rd = s_q.sel[0];
            `HPP_SEL2_OFF: rd = s_q.sel[1];
            `HPP_SEL3_OFF: rd = s_q.sel[2];
            `HPP_SMO1_OFF: rd = {16'h0000, s_q.smo[0]};
            `HPP_SMO2_OFF: rd = {16'h0000, s_q.smo[1]};
            `HPP_SMO3_OFF: rd = {16'h0000, s_q.smo[2]};
            `HPP_EN_OFF: rd = {29'h0, s_q.en};
            `HPP_STAT_OFF: rd = {28'h0, s_q.st};
            `HPP_CLR_OFF: rd = '0;
            `HPP_IEN_OFF: rd = {28'h0, s_q.ien};
            `HPP_ERR1_OFF: rd = s_q.errw[0];
            `HPP_ERR2_OFF: rd = s_q.errw[1];
            `HPP_ERR3_OFF: rd = s_q.errw[2];
            `HPP_MINOR_OFF: rd = s_q.minor;
            `HPP_MCLR_OFF: rd = '0;
            `HPP_ACC_OFF: rd = s_q.acc;
            default: hit = 1'b0;
         endcase
      end
      s_d.pready = psel && !penable;
      if (psel && !penable) begin
         s_d.prdata = rd;
         s_d.pslverr = !hit;
      end

      // APB writes take effect at the completing access edge
      wr = psel && penable && pwrite && s_q.pready;
      if (wr) begin
         if (paddr[11:8] == `HPP_GAIN_PAGE && !paddr[7]) begin
            s_d.gain[paddr[6:2]] = pwdata[15:0];
         end else begin
            unique case (paddr)
               `HPP_SEL1_OFF: s_d.sel[0] = pwdata;
               `HPP_SEL2_OFF: s_d.sel[1] = pwdata;
               `HPP_SEL3_OFF: s_d.sel[2] = pwdata;
               `HPP_SMO1_OFF: s_d.smo[0] = pwdata[15:0];
               `HPP_SMO2_OFF: s_d.smo[1] = pwdata[15:0];
               `HPP_SMO3_OFF: s_d.smo[2] = pwdata[15:0];
               `HPP_EN_OFF: s_d.en = pwdata[2:0];
               `HPP_CLR_OFF: s_d.st = s_q.st & ~pwdata[3:0];
               `HPP_IEN_OFF: s_d.ien = pwdata[3:0];
               `HPP_MCLR_OFF: s_d.minor = s_q.minor & ~pwdata;
               default: ;
            endcase
         end
      end

      // Generators; hardware sets below win over the clears above
      s_d.acc = '0;
      for (int g = 0; g < 3; g++) begin
         s_d.g[g].en_q = s_q.en[g];
         s_d.cmd[g].stb = 1'b0;
         sl = first3(s_q.sel[g] & `HPP_AXIS_MASK);
         if (s_q.en[g] && !s_q.g[g].en_q) begin
            conflict = 1'b0;
            bad = '0;
            busy_m = axis_busy | s_q.acc;
            for (int k = 0; k < 3; k++) begin
               if (sl.v[k] && busy_m[sl.ax[k]]) begin
                  conflict = 1'b1;
                  s_d.minor[sl.ax[k]] = 1'b1;
               end
            end
            if (conflict) begin
               s_d.st[`HPP_STAT_MINOR_BIT] = 1'b1;
            end else if (sl.v != 3'b000) begin
               s_d.g[g].act = 1'b1;
               s_d.g[g].sl = sl;
               for (int k = 0; k < 3; k++) begin
                  gn = s_q.gain[sl.ax[k]];
                  if (gn < `HPP_GAIN_MIN || gn > `HPP_GAIN_MAX) begin
                     gn = `HPP_GAIN_MIN;
                     bad[sl.ax[k]] = sl.v[k];
                  end
                  s_d.g[g].gain[k] = sl.v[k] ? gn : 16'h0000;
               end
               s_d.errw[g] = bad;
               if (bad != '0) begin
                  s_d.st[g] = 1'b1;
               end
            end
         end else if (!s_q.en[g]) begin
            s_d.g[g].act = 1'b0;
         end

         // Pulses of the first input module only count while active
         inc = gen_pulse[g] ? (gen_dir[g] ? -16'sd1 : 16'sd1) : 16'sd0;
         smp = s_q.g[g].cnt + inc;
         if (!s_q.g[g].act) begin
            smp = '0;
         end
         s_d.g[g].cnt = tick ? 16'sd0 : smp;
         if (tick) begin
            s_d.g[g].smp = smp;
            tgt = s_q.g[g].act ? 32'(smp) <<< `HPP_FILT_FRAC : 32'sd0;
            smo = (s_q.smo[g] > `HPP_SMO_MAX) ? `HPP_SMO_MAX : s_q.smo[g];
            den = 40'(({24'h0, smo} + 40'd1) * `HPP_TAU_UNIT_TENTHS_MS);
            num = 40'(40'(tgt - s_q.g[g].filt) * `HPP_TAU_SCALE);
            step = num / den;
            if (step == 40'sd0 && num != 40'sd0) begin
               step = (num < 0) ? -40'sd1 : 40'sd1;
            end
            s_d.g[g].filt = s_q.g[g].filt + 32'(step);
            s_d.cmd[g].stb = 1'b1;
            s_d.cmd[g].sl = s_q.g[g].sl;
            for (int k = 0; k < 3; k++) begin
               // Travel in per-pulse units of the axis
               s_d.cmd[g].travel[k] = 32'(smp) * 32'($signed({1'b0, s_q.g[g].gain[k]}));
               s_d.cmd[g].speed[k] = (s_q.g[g].filt >>> `HPP_FILT_FRAC)
                  * 32'($signed({1'b0, s_q.g[g].gain[k]}));
            end
         end
         // Axes stay held until the smoothed stop has settled
         if (s_d.g[g].act || s_d.g[g].filt != 32'sd0) begin
            for (int k = 0; k < 3; k++) begin
               if (s_d.g[g].sl.v[k]) begin
                  s_d.acc[s_d.g[g].sl.ax[k]] = 1'b1;
               end
            end
         end else begin
            s_d.g[g].sl = '0;
         end
      end
      s_d.irq = |(s_d.st & s_d.ien);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= RST_S;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign cmd = s_q.cmd;
   assign start_accepted = s_q.acc;
   assign irq = s_q.irq;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_apb_ready_next: assert property (psel && !penable |=> pready && psel)
      else $error("pready missing in access phase");
   a_tick_strobe: assert property (s_q.tick == 16'(TICK_CYC - 1) |=> cmd[0].stb ##1 !cmd[0].stb)
      else $error("command strobe not one cycle after tick");
   a_idle_no_travel: assert property (cmd[0].stb && !$past(s_q.g[0].act) |-> cmd[0].travel == '0)
      else $error("travel while disabled");
   a_travel_product: assert property (cmd[0].stb |-> cmd[0].travel[0]
      == 32'(s_q.g[0].smp) * 32'($signed({1'b0, $past(s_q.g[0].gain[0])})))
      else $error("travel not pulses times gain");
   a_gain_legal: assert property (s_q.g[0].act && s_q.g[0].sl.v[0] |->
      s_q.g[0].gain[0] >= `HPP_GAIN_MIN && s_q.g[0].gain[0] <= `HPP_GAIN_MAX)
      else $error("out of range gain in use");
   a_slots_packed: assert property (s_q.g[0].sl.v inside {3'b000, 3'b001, 3'b011, 3'b111})
      else $error("slots not lowest first");
   a_empty_select: assert property ($rose(s_q.g[0].act) |->
      ($past(s_q.sel[0]) & `HPP_AXIS_MASK) != '0)
      else $error("started with no axis selected");
   a_busy_refuse: assert property ($rose(s_q.g[0].act) |->
      ($past(axis_busy) & slot_mask[0]) == '0)
      else $error("started on a moving axis");
   a_acc_held: assert property (s_q.g[0].act |-> (slot_mask[0] & ~start_accepted) == '0)
      else $error("start accepted not held");
   a_decel_decay: assert property (s_q.tick == 16'(TICK_CYC - 1) && !s_q.g[0].act
      && s_q.g[0].filt > 0 |=> s_q.g[0].filt < $past(s_q.g[0].filt))
      else $error("smoothed speed not decaying");
   a_irq_follow: assert property ($rose(s_q.st[0]) && s_q.ien[0] |-> irq)
      else $error("irq not raised");
endmodule : hpp_top
`default_nettype wire

//--- verilog/hpp_params.svh
`ifndef HPP_PARAMS_SVH
`define HPP_PARAMS_SVH
// Register byte offsets
`define HPP_SEL1_OFF 12'h000
`define HPP_SEL2_OFF 12'h004
`define HPP_SEL3_OFF 12'h008
`define HPP_SMO1_OFF 12'h00C
`define HPP_SMO2_OFF 12'h010
`define HPP_SMO3_OFF 12'h014
`define HPP_EN_OFF 12'h018
`define HPP_STAT_OFF 12'h01C
`define HPP_CLR_OFF 12'h020
`define HPP_IEN_OFF 12'h024
`define HPP_ERR1_OFF 12'h028
`define HPP_ERR2_OFF 12'h02C
`define HPP_ERR3_OFF 12'h030
`define HPP_MINOR_OFF 12'h034
`define HPP_MCLR_OFF 12'h038
`define HPP_ACC_OFF 12'h03C
`define HPP_GAIN_PAGE 4'h1
// Field positions and limits
`define HPP_STAT_MINOR_BIT 3
`define HPP_GAIN_RST 16'h0001
`define HPP_GAIN_MIN 16'h0001
`define HPP_GAIN_MAX 16'h2710
`define HPP_SMO_MAX 16'h003B
// Axes served: all ones for 32, 32'h0000FFFF or 32'h000000FF on smaller parts
`define HPP_AXIS_MASK 32'hFFFFFFFF
// Timing
`define HPP_CLK_NS 40
`define HPP_TICK_NS 1000000
`define HPP_TAU_UNIT_TENTHS_MS 568
`define HPP_TAU_SCALE 10
`define HPP_FILT_FRAC 8
`endif

//--- verilog/hpp_pkg.sv
`default_nettype none
package hpp_pkg;
   typedef struct packed {
      logic [2:0] v;
      logic [2:0][4:0] ax;
   } hpp_slot_s;
   typedef struct packed {
      hpp_slot_s sl;
      logic [2:0][15:0] gain;
      logic signed [15:0] cnt;
      logic signed [15:0] smp;
      logic signed [31:0] filt;
      logic en_q;
      logic act;
   } hpp_gen_s;
   typedef struct packed {
      logic stb;
      hpp_slot_s sl;
      logic [2:0][31:0] travel;
      logic [2:0][31:0] speed;
   } hpp_cmd_s;
   typedef struct packed {
      hpp_gen_s [2:0] g;
      hpp_cmd_s [2:0] cmd;
      logic [2:0][31:0] sel;
      logic [2:0][15:0] smo;
      logic [31:0][15:0] gain;
      logic [2:0] en;
      logic [31:0] acc;
      logic [2:0][31:0] errw;
      logic [31:0] minor;
      logic [3:0] st;
      logic [3:0] ien;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [15:0] tick;
   } hpp_state_s;
endpackage : hpp_pkg
`default_nettype wire

//--- test/hpp_gen_model.sv
`default_nettype none
module hpp_gen_model (
   input wire logic pclk,
   output logic [2:0] gen_pulse,
   output logic [2:0] gen_dir
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      gen_pulse = 3'h0;
      gen_dir = 3'h0;
   end
   // Counts on the first input module, one every two cycles, direction set first
   task automatic burst(input int g, input int n, input logic down);
      @(posedge pclk);
      gen_dir[g] <= down;
      repeat (n) begin
         @(posedge pclk);
         gen_pulse[g] <= 1'b1;
         @(posedge pclk);
         gen_pulse[g] <= 1'b0;
      end
   endtask : burst
endmodule : hpp_gen_model
`default_nettype wire

//--- test/handwheel_pulse_positioning_test.sv
`include "hpp_params.svh"
`default_nettype none
module handwheel_pulse_positioning_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, axis_busy, start_accepted, rd;
   logic [2:0] gen_pulse, gen_dir;
   hpp_pkg::hpp_cmd_s [2:0] cmd;
   int errors, total_checks;
   hpp_top #(.TICK_CYC(50)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .gen_pulse(gen_pulse), .gen_dir(gen_dir), .axis_busy(axis_busy),
      .cmd(cmd), .start_accepted(start_accepted), .irq(irq));
   hpp_gen_model gen_u (.pclk(pclk), .gen_pulse(gen_pulse), .gen_dir(gen_dir));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("errors=%0d total_checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   task automatic tmo;
      errors++;
      $display("mismatch at %0t: wait ran out", $time);
      finish_test();
   endtask : tmo
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Look at pready while it stands, before the edge that completes the access
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) tmo();
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string m);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, m);
   endtask : rdchk
   task automatic set_en(input logic [2:0] v);
      apb(1'b1, `HPP_EN_OFF, {29'h0, v});
      repeat (3) @(posedge pclk);
   endtask : set_en
   task automatic wstb(input int g);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (cmd[g].stb !== 1'b1 && n < 200);
      if (n >= 200) tmo();
   endtask : wstb
   task automatic irqchk(input logic exp, input string m);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, {31'h0, exp}, m);
   endtask : irqchk
   ////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rdchk(12'h17C, 32'h1, "gain reset");
      apb(1'b1, `HPP_SEL1_OFF, 32'h80000001);
      rdchk(`HPP_SEL1_OFF, 32'h80000001, "select word");
      apb(1'b1, `HPP_SMO1_OFF, 32'h3C);
      rdchk(`HPP_SMO1_OFF, 32'h3C, "smoothing stored");
      apb(1'b1, `HPP_SMO1_OFF, 32'h0);
      apb(1'b0, 12'h0FC, 32'h0);
      chk({31'h0, er}, 32'h1, "unmapped");
   endtask : t_regs
   task automatic t_travel;
      apb(1'b1, `HPP_SEL1_OFF, 32'h6);
      apb(1'b1, 12'h104, 32'h3);
      apb(1'b1, 12'h108, 32'h2710);
      gen_u.burst(0, 3, 1'b0);
      chk(start_accepted, 32'h0, "idle");
      set_en(3'b001);
      chk(start_accepted, 32'h6, "accepted");
      wstb(0);
      gen_u.burst(0, 7, 1'b0);
      wstb(0);
      chk({29'h0, cmd[0].sl.v}, 32'h3, "slots");
      chk({27'h0, cmd[0].sl.ax[1]}, 32'h2, "slot axis");
      chk(cmd[0].travel[0], 32'h15, "travel");
      chk(cmd[0].travel[1], 32'h11170, "travel max gain");
      gen_u.burst(0, 5, 1'b1);
      wstb(0);
      chk(cmd[0].travel[1], 32'hFFFF3CB0, "travel down");
      wstb(0);
      chk(cmd[0].travel[0], 32'h0, "count cleared");
      set_en(3'b000);
      for (int i = 0; i < 30000 && start_accepted !== 32'h0; i++) @(posedge pclk);
      if (start_accepted !== 32'h0) tmo();
      chk(start_accepted, 32'h0, "released");
   endtask : t_travel
   task automatic t_sel4;
      apb(1'b1, `HPP_SEL2_OFF, 32'hF00);
      set_en(3'b010);
      chk(start_accepted, 32'h700, "lowest three");
      wstb(1);
      chk({17'h0, cmd[1].sl.ax}, 32'h2928, "slot axes");
      gen_u.burst(1, 4, 1'b0);
      wstb(1);
      chk(cmd[1].travel[2], 32'h4, "third slot");
   endtask : t_sel4
   task automatic t_badgain;
      apb(1'b1, 12'h140, 32'h0);
      apb(1'b1, 12'h144, 32'h2711);
      apb(1'b1, `HPP_SEL3_OFF, 32'h30000);
      set_en(3'b110);
      rdchk(`HPP_ERR3_OFF, 32'h30000, "error word");
      rdchk(`HPP_STAT_OFF, 32'h4, "error flag");
      irqchk(1'b0, "masked irq");
      apb(1'b1, `HPP_IEN_OFF, 32'hF);
      irqchk(1'b1, "irq");
      wstb(2);
      gen_u.burst(2, 3, 1'b0);
      wstb(2);
      chk(cmd[2].travel[1], 32'h3, "gain fallback");
      apb(1'b1, `HPP_CLR_OFF, 32'h4);
      rdchk(`HPP_STAT_OFF, 32'h0, "cleared");
      irqchk(1'b0, "irq low");
   endtask : t_badgain
   task automatic t_busy;
      axis_busy <= 32'h01000000;
      apb(1'b1, `HPP_SEL1_OFF, 32'h01000000);
      set_en(3'b111);
      rdchk(`HPP_MINOR_OFF, 32'h01000000, "busy axis");
      rdchk(`HPP_STAT_OFF, 32'h8, "busy flag");
      chk(start_accepted, 32'h30700, "busy refused");
      apb(1'b1, `HPP_MCLR_OFF, 32'hFFFFFFFF);
      apb(1'b1, `HPP_CLR_OFF, 32'hF);
      axis_busy <= 32'h0;
      set_en(3'b110);
      apb(1'b1, `HPP_SEL1_OFF, 32'h0);
      set_en(3'b111);
      rdchk(`HPP_STAT_OFF, 32'h0, "empty select");
      chk(start_accepted, 32'h30700, "no start");
   endtask : t_busy
   ////////////////////////////////////////////////////////////////
   initial begin
      errors = 0;
      total_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      axis_busy = 32'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_travel();
      t_sel4();
      t_badgain();
      t_busy();
      finish_test();
   end
endmodule : handwheel_pulse_positioning_test
`default_nettype wire
